// ===== tcsc_cfg.svh
`ifndef TCSC_CFG_SVH
`define TCSC_CFG_SVH

// Register offsets on the plain register port
`define TCSC_OFF_TIMER_SC 3'h0
`define TCSC_OFF_MOD_HIGH 3'h1
`define TCSC_OFF_MOD_LOW 3'h2
`define TCSC_OFF_CHAN_SC 3'h3
`define TCSC_OFF_VAL_HIGH 3'h4
`define TCSC_OFF_VAL_LOW 3'h5
`define TCSC_OFF_IRQ_STAT 3'h6
`define TCSC_OFF_IRQ_MASK 3'h7

// channel_status_control field positions
`define TCSC_BIT_EVENT_FLAG 7
`define TCSC_BIT_IRQ_ENABLE 6
`define TCSC_BIT_MODE_HIGH 5
`define TCSC_BIT_MODE_LOW 4
`define TCSC_BIT_ELS_HIGH 3
`define TCSC_BIT_ELS_LOW 2

// timer_status_control field positions
`define TCSC_BIT_CENTER_PWM 5

// Interrupt status/mask bit positions
`define TCSC_IRQ_CAPTURE 0
`define TCSC_IRQ_MATCH 1

// Reset values
`define TCSC_RST_CHAN_SC 8'h00
`define TCSC_RST_TIMER_SC 8'h00
`define TCSC_RST_MODULO 16'hffff
`define TCSC_RST_VALUE 16'h0000
`define TCSC_RST_IRQ 2'h0

`endif

// ===== tcsc_pkg.sv
package tcsc_pkg;

    typedef enum logic [1:0] {
        MODE_CAPTURE,
        MODE_COMPARE,
        MODE_EDGE_PWM,
        MODE_CENTER_PWM
    } tcsc_mode_t;

    typedef logic [7:0] tcsc_byte_t;

endpackage : tcsc_pkg

// ===== tcsc_pin_if.sv
`timescale 1ns/100ps
`default_nettype none

interface tcsc_pin_if;
    logic level;
    logic rise;
    logic fall;

    modport src (output level, output rise, output fall);
    modport sink (input level, input rise, input fall);
endinterface : tcsc_pin_if

`default_nettype wire

// ===== tcsc_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none

module tcsc_pin_sync (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Raw pin and conditioned view
    input wire logic pinIn,
    tcsc_pin_if.src pinView
);

    logic meta_q, meta_d;
    logic stable_q, stable_d;
    logic prev_q, prev_d;

    always_comb
    begin
        meta_d = pinIn;
        stable_d = meta_q;
        prev_d = stable_q;
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_q <= 1'b0;
            stable_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            meta_q <= meta_d;
            stable_q <= stable_d;
            prev_q <= prev_d;
        end
    end

    // Edges seen only on the second and third stages
    assign pinView.level = stable_q;
    assign pinView.rise = stable_q & ~prev_q;
    assign pinView.fall = ~stable_q & prev_q;

endmodule : tcsc_pin_sync

`default_nettype wire

// ===== tcsc_channel.sv
// Overview of operation
// - Capture mode: selected active pin edge sets the channel event flag.
// - Compare or PWM mode: counter equal to channel value sets the flag.
// - PWM with 0% or 100% duty never sets the flag.
// - Channel interrupt while flag and enable are set; reset clears enable.
// - Flag clears only by a read while set, then a write of 0.
// - New event during the clear sequence restarts it; flag stays set.
// - Writing 1 to the flag does nothing; reset clears it.
// - Center PWM off and mode high set selects edge-aligned PWM.
// - Center PWM off, mode high clear: mode low picks capture or compare.
// - Edge/level field picks capture edge, compare level or PWM polarity.
// - Edge/level field 00 releases the pin whatever the mode.
// - In debug halt the modulo coherency latches stay frozen.
// - In debug halt modulo writes go straight to the modulo register.
// - A timer status write resets the coherency, even in debug halt.
// - Debug halt means program stopped, awaiting serial debug commands.
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "tcsc_cfg.svh"

module tcsc_channel (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Register port
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    // Timer datapath
    input wire logic [15:0] countIn,
    output logic [15:0] moduloValue,
    // Debug state
    input wire logic backgroundDebugMode,
    // Channel pin
    input wire logic chanPinIn,
    output logic chanPinOut,
    output logic chanPinOe,
    // Interrupts
    output logic chanIrq,
    output logic irq
);

    tcsc_pin_if pinView ();

    tcsc_pin_sync u_sync (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .pinIn(chanPinIn),
        .pinView(pinView.src)
    );

    // Register decode
    logic wrTimerSc, wrModHigh, wrModLow, wrChanSc, wrValHigh, wrValLow, wrMask;
    logic rdChanSc, rdIrqStat;

    assign wrTimerSc = regWr && (regAddr == `TCSC_OFF_TIMER_SC);
    assign wrModHigh = regWr && (regAddr == `TCSC_OFF_MOD_HIGH);
    assign wrModLow = regWr && (regAddr == `TCSC_OFF_MOD_LOW);
    assign wrChanSc = regWr && (regAddr == `TCSC_OFF_CHAN_SC);
    assign wrValHigh = regWr && (regAddr == `TCSC_OFF_VAL_HIGH);
    assign wrValLow = regWr && (regAddr == `TCSC_OFF_VAL_LOW);
    assign wrMask = regWr && (regAddr == `TCSC_OFF_IRQ_MASK);
    assign rdChanSc = regRd && (regAddr == `TCSC_OFF_CHAN_SC);
    assign rdIrqStat = regRd && (regAddr == `TCSC_OFF_IRQ_STAT);

    // Control and status state
    tcsc_pkg::tcsc_byte_t timerSc_q, timerSc_d;
    logic eventFlag_q, eventFlag_d;
    logic irqEnable_q, irqEnable_d;
    logic modeHigh_q, modeHigh_d;
    logic modeLow_q, modeLow_d;
    logic [1:0] edgeLevel_q, edgeLevel_d;
    logic clearArmed_q, clearArmed_d;
    logic [15:0] value_q, value_d;
    logic [15:0] modulo_q, modulo_d;
    logic [7:0] modHighBuf_q, modHighBuf_d;
    logic [7:0] modLowBuf_q, modLowBuf_d;
    logic modHighSeen_q, modHighSeen_d;
    logic modLowSeen_q, modLowSeen_d;
    logic [1:0] irqStat_q, irqStat_d;
    logic [1:0] irqMask_q, irqMask_d;
    logic pinOut_q, pinOut_d;
    logic [7:0] rdData_q, rdData_d;

    // Mode decode
    tcsc_pkg::tcsc_mode_t mode;
    logic centerPwm;
    logic pinReleased;
    logic isPwm;
    logic match;
    logic dutyEdge;
    logic captureEdge;
    logic chanEvent;
    logic pwmActive;
    logic [7:0] chanScView;

    assign centerPwm = timerSc_q[`TCSC_BIT_CENTER_PWM];
    assign pinReleased = (edgeLevel_q == 2'h0);

    always_comb
    begin
        if (centerPwm)
            mode = tcsc_pkg::MODE_CENTER_PWM;
        else if (modeHigh_q)
            mode = tcsc_pkg::MODE_EDGE_PWM;
        else if (modeLow_q)
            mode = tcsc_pkg::MODE_COMPARE;
        else
            mode = tcsc_pkg::MODE_CAPTURE;
    end

    assign isPwm = (mode == tcsc_pkg::MODE_EDGE_PWM) || (mode == tcsc_pkg::MODE_CENTER_PWM);
    assign match = (countIn == value_q);
    // Duty of 0% is a zero value, 100% is a value past the modulo
    assign dutyEdge = isPwm && ((value_q == 16'h0000) || (value_q > modulo_q));
    assign pwmActive = (countIn < value_q);

    // Capture edge polarity from the edge/level field; spurious edges
    // after a mode change are avoided by software holding the pin
    always_comb
    begin
        case (edgeLevel_q)
            2'h1: captureEdge = pinView.rise;
            2'h2: captureEdge = pinView.fall;
            2'h3: captureEdge = pinView.rise | pinView.fall;
            default: captureEdge = 1'b0;
        endcase
    end

    always_comb
    begin
        case (mode)
            tcsc_pkg::MODE_CAPTURE: chanEvent = captureEdge;
            tcsc_pkg::MODE_COMPARE: chanEvent = match;
            tcsc_pkg::MODE_EDGE_PWM, tcsc_pkg::MODE_CENTER_PWM: chanEvent = match && !dutyEdge;
            default: chanEvent = 1'b0;
        endcase
    end

    assign chanScView = {eventFlag_q, irqEnable_q, modeHigh_q, modeLow_q, edgeLevel_q, 2'h0};

    // Channel status and control
    always_comb
    begin
        eventFlag_d = eventFlag_q;
        clearArmed_d = clearArmed_q;
        irqEnable_d = irqEnable_q;
        modeHigh_d = modeHigh_q;
        modeLow_d = modeLow_q;
        edgeLevel_d = edgeLevel_q;
        if (wrChanSc)
        begin
            irqEnable_d = regWrData[`TCSC_BIT_IRQ_ENABLE];
            modeHigh_d = regWrData[`TCSC_BIT_MODE_HIGH];
            modeLow_d = regWrData[`TCSC_BIT_MODE_LOW];
            edgeLevel_d = {regWrData[`TCSC_BIT_ELS_HIGH], regWrData[`TCSC_BIT_ELS_LOW]};
            clearArmed_d = 1'b0;
            if (clearArmed_q && !regWrData[`TCSC_BIT_EVENT_FLAG])
                eventFlag_d = 1'b0;
        end
        if (rdChanSc && eventFlag_q)
            clearArmed_d = 1'b1;
        if (chanEvent)
        begin
            eventFlag_d = 1'b1;
            clearArmed_d = 1'b0;
        end
    end

    // Channel value: written by software, loaded by a capture
    always_comb
    begin
        value_d = value_q;
        if (wrValHigh)
            value_d[15:8] = regWrData;
        if (wrValLow)
            value_d[7:0] = regWrData;
        if (mode == tcsc_pkg::MODE_CAPTURE && captureEdge)
            value_d = countIn;
    end

    // Modulo with write coherency
    always_comb
    begin
        timerSc_d = timerSc_q;
        modulo_d = modulo_q;
        modHighBuf_d = modHighBuf_q;
        modLowBuf_d = modLowBuf_q;
        modHighSeen_d = modHighSeen_q;
        modLowSeen_d = modLowSeen_q;
        if (backgroundDebugMode)
        begin
            if (wrModHigh)
                modulo_d[15:8] = regWrData;
            if (wrModLow)
                modulo_d[7:0] = regWrData;
        end
        else
        begin
            if (wrModHigh)
            begin
                modHighBuf_d = regWrData;
                modHighSeen_d = 1'b1;
            end
            if (wrModLow)
            begin
                modLowBuf_d = regWrData;
                modLowSeen_d = 1'b1;
            end
            if (modHighSeen_d && modLowSeen_d)
            begin
                modulo_d = {modHighBuf_d, modLowBuf_d};
                modHighSeen_d = 1'b0;
                modLowSeen_d = 1'b0;
            end
        end
        if (wrTimerSc)
        begin
            timerSc_d = regWrData;
            modHighSeen_d = 1'b0;
            modLowSeen_d = 1'b0;
        end
    end

    // Pin output level
    always_comb
    begin
        pinOut_d = pinOut_q;
        case (mode)
            tcsc_pkg::MODE_COMPARE:
                if (match)
                begin
                    case (edgeLevel_q)
                        2'h1: pinOut_d = ~pinOut_q;
                        2'h2: pinOut_d = 1'b0;
                        2'h3: pinOut_d = 1'b1;
                        default: pinOut_d = pinOut_q;
                    endcase
                end
            tcsc_pkg::MODE_EDGE_PWM, tcsc_pkg::MODE_CENTER_PWM:
                pinOut_d = edgeLevel_q[0] ? ~pwmActive : pwmActive;
            default: pinOut_d = 1'b0;
        endcase
    end

    // Interrupt status, mask and read data
    always_comb
    begin
        irqStat_d = irqStat_q;
        irqMask_d = irqMask_q;
        rdData_d = 8'h00;
        if (wrMask)
            irqMask_d = regWrData[1:0];
        if (rdIrqStat)
            irqStat_d = 2'h0;
        if (chanEvent && mode == tcsc_pkg::MODE_CAPTURE)
            irqStat_d[`TCSC_IRQ_CAPTURE] = 1'b1;
        if (chanEvent && mode != tcsc_pkg::MODE_CAPTURE)
            irqStat_d[`TCSC_IRQ_MATCH] = 1'b1;
        if (regRd)
        begin
            case (regAddr)
                `TCSC_OFF_TIMER_SC: rdData_d = timerSc_q;
                `TCSC_OFF_MOD_HIGH: rdData_d = modulo_q[15:8];
                `TCSC_OFF_MOD_LOW: rdData_d = modulo_q[7:0];
                `TCSC_OFF_CHAN_SC: rdData_d = chanScView;
                `TCSC_OFF_VAL_HIGH: rdData_d = value_q[15:8];
                `TCSC_OFF_VAL_LOW: rdData_d = value_q[7:0];
                `TCSC_OFF_IRQ_STAT: rdData_d = {6'h00, irqStat_q};
                `TCSC_OFF_IRQ_MASK: rdData_d = {6'h00, irqMask_q};
                default: rdData_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            timerSc_q <= `TCSC_RST_TIMER_SC;
            eventFlag_q <= 1'b0;
            irqEnable_q <= 1'b0;
            modeHigh_q <= 1'b0;
            modeLow_q <= 1'b0;
            edgeLevel_q <= 2'h0;
            clearArmed_q <= 1'b0;
            value_q <= `TCSC_RST_VALUE;
            modulo_q <= `TCSC_RST_MODULO;
            modHighBuf_q <= 8'h00;
            modLowBuf_q <= 8'h00;
            modHighSeen_q <= 1'b0;
            modLowSeen_q <= 1'b0;
            irqStat_q <= `TCSC_RST_IRQ;
            irqMask_q <= `TCSC_RST_IRQ;
            pinOut_q <= 1'b0;
            rdData_q <= 8'h00;
        end
        else
        begin
            timerSc_q <= timerSc_d;
            eventFlag_q <= eventFlag_d;
            irqEnable_q <= irqEnable_d;
            modeHigh_q <= modeHigh_d;
            modeLow_q <= modeLow_d;
            edgeLevel_q <= edgeLevel_d;
            clearArmed_q <= clearArmed_d;
            value_q <= value_d;
            modulo_q <= modulo_d;
            modHighBuf_q <= modHighBuf_d;
            modLowBuf_q <= modLowBuf_d;
            modHighSeen_q <= modHighSeen_d;
            modLowSeen_q <= modLowSeen_d;
            irqStat_q <= irqStat_d;
            irqMask_q <= irqMask_d;
            pinOut_q <= pinOut_d;
            rdData_q <= rdData_d;
        end
    end

    assign regRdData = rdData_q;
    assign moduloValue = modulo_q;
    assign chanPinOut = pinOut_q;
    // Capture only listens; released pin is left to other users
    assign chanPinOe = !pinReleased && (mode != tcsc_pkg::MODE_CAPTURE);
    assign chanIrq = eventFlag_q && irqEnable_q;
    assign irq = |(irqStat_q & irqMask_q);

endmodule : tcsc_channel

`default_nettype wire

// ===== tcsc_channel_chk.sv
`timescale 1ns/100ps
`default_nettype none

module tcsc_channel_chk (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Register port
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdData,
    // Outputs and debug state watched
    input wire logic [15:0] moduloValue,
    input wire logic backgroundDebugMode,
    input wire logic chanPinOe,
    input wire logic chanIrq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    irq_match_a: assert property ($past(regRd && regAddr == 3'h3) |->
        (regRdData[7] & regRdData[6]) == $past(chanIrq)) else $error("irq differs from flag and enable");
    irq_fall_a: assert property ($fell(chanIrq) |-> $past(regWr && regAddr == 3'h3))
        else $error("irq fell without a control write");
    pin_release_a: assert property ($past(regWr && regAddr == 3'h3 && regWrData[3:2] == 2'h0) |->
        !chanPinOe) else $error("pin driven with edge level 00");
    cmp_drive_a: assert property ($past(regWr && regAddr == 3'h3 && regWrData[4] && regWrData[3:2] != 2'h0)
        |-> chanPinOe) else $error("compare pin not driven");
    pwm_drive_a: assert property ($past(regWr && regAddr == 3'h3 && regWrData[5] && regWrData[3:2] != 2'h0)
        |-> chanPinOe) else $error("pwm pin not driven");
    mod_hi_a: assert property ($past(regWr && regAddr == 3'h1 && backgroundDebugMode) |->
        moduloValue[15:8] == $past(regWrData)) else $error("debug high write not direct");
    mod_lo_a: assert property ($past(regWr && regAddr == 3'h2 && backgroundDebugMode) |->
        moduloValue[7:0] == $past(regWrData)) else $error("debug low write not direct");
    mod_steady_a: assert property (!$past(regWr && (regAddr == 3'h1 || regAddr == 3'h2)) |->
        $stable(moduloValue)) else $error("modulo changed without a write");
    rsvd_zero_a: assert property ($past(regRd && regAddr == 3'h3) |-> regRdData[1:0] == 2'h0)
        else $error("reserved control bits not zero");
endmodule : tcsc_channel_chk

bind tcsc_channel tcsc_channel_chk chk (.ref_clk(ref_clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .moduloValue(moduloValue),
    .backgroundDebugMode(backgroundDebugMode), .chanPinOe(chanPinOe), .chanIrq(chanIrq));

`default_nettype wire

// ===== tcsc_pin_model.sv
`timescale 1ns/100ps
`default_nettype none

module tcsc_pin_model (
    // Far side drive
    input wire logic drvLevel,
    // Channel side
    input wire logic chanPinOut,
    input wire logic chanPinOe,
    output logic pinLevel
);
    // Wire level: the channel wins while it drives, else the outside source
    assign pinLevel = chanPinOe ? chanPinOut : drvLevel;
endmodule : tcsc_pin_model

`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    typedef struct packed {logic [1:0] els; logic from; logic to; logic flag;} tcsc_row_t;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [2:0] regAddr = 3'h0;
    logic [7:0] regWrData = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [15:0] countIn = 16'h0000;
    logic backgroundDebugMode = 1'b0;
    logic drvLevel = 1'b0;
    logic [7:0] regRdData, rd;
    logic [15:0] moduloValue;
    logic pinLevel, chanPinOut, chanPinOe, chanIrq, irq;
    int num_errors = 0;
    int tests_run = 0;
    tcsc_row_t rows [7] = '{'{2'h1, 1'b0, 1'b1, 1'b1}, '{2'h1, 1'b1, 1'b0, 1'b0}, '{2'h2, 1'b1, 1'b0, 1'b1},
        '{2'h2, 1'b0, 1'b1, 1'b0}, '{2'h3, 1'b0, 1'b1, 1'b1}, '{2'h3, 1'b1, 1'b0, 1'b1}, '{2'h0, 1'b0, 1'b1, 1'b0}};

    always #5 ref_clk = ~ref_clk;

    tcsc_channel uut (.ref_clk(ref_clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .countIn(countIn), .moduloValue(moduloValue),
        .backgroundDebugMode(backgroundDebugMode), .chanPinIn(pinLevel), .chanPinOut(chanPinOut),
        .chanPinOe(chanPinOe), .chanIrq(chanIrq), .irq(irq));
    tcsc_pin_model pin (.drvLevel(drvLevel), .chanPinOut(chanPinOut), .chanPinOe(chanPinOe), .pinLevel(pinLevel));

    task automatic wrap_up;
        $display("errors=%0d checks=%0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic cmp1(input logic got, input logic exp);
        cmp({15'h0000, got}, {15'h0000, exp});
    endtask : cmp1

    // One write, then an idle cycle so strobes never restart in one step
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
        @(posedge ref_clk);
    endtask : wr

    task automatic rdr(input logic [2:0] a);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 rd = regRdData;
        @(posedge ref_clk);
    endtask : rdr

    task automatic pulse(input logic lvl);
        drvLevel <= lvl;
        repeat (5) @(posedge ref_clk);
    endtask : pulse

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        wrap_up();
    end

    initial
    begin
        repeat (6) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        cmp(moduloValue, 16'hffff);
        rdr(3'h3);
        cmp1(rd == 8'h00, 1'b1);
        wr(3'h7, 8'h01);
        foreach (rows[i])
        begin
            pulse(rows[i].from);
            wr(3'h3, {4'h4, rows[i].els, 2'h0});
            repeat (4) @(posedge ref_clk);
            rdr(3'h3);
            wr(3'h3, {4'h4, rows[i].els, 2'h0});
            rdr(3'h6);
            pulse(rows[i].to);
            cmp1(chanIrq, rows[i].flag);
            cmp1(irq, rows[i].flag);
            rdr(3'h3);
            cmp({8'h00, rd}, {8'h00, rows[i].flag, 3'h4, rows[i].els, 2'h0});
        end
        cmp1(chanPinOe, 1'b0);
        wr(3'h3, 8'h4c);
        cmp1(chanPinOe, 1'b0);
        wr(3'h7, 8'h00);
        rdr(3'h6);
        pulse(1'b0);
        cmp1(irq, 1'b0);
        wr(3'h7, 8'h01);
        cmp1(irq, 1'b1);
        rdr(3'h6);
        cmp1(irq, 1'b0);
        wr(3'h3, 8'hcc);
        cmp1(chanIrq, 1'b1);
        wr(3'h3, 8'h4c);
        cmp1(chanIrq, 1'b1);
        rdr(3'h3);
        countIn <= 16'h005a;
        pulse(1'b1);
        wr(3'h3, 8'h4c);
        cmp1(chanIrq, 1'b1);
        rdr(3'h5);
        cmp({8'h00, rd}, 16'h005a);
        rdr(3'h3);
        wr(3'h3, 8'h4c);
        cmp1(chanIrq, 1'b0);
        wr(3'h4, 8'h00);
        wr(3'h5, 8'h10);
        wr(3'h3, 8'h5c);
        countIn <= 16'h0010;
        repeat (3) @(posedge ref_clk);
        cmp1(chanIrq, 1'b1);
        cmp1(chanPinOut, 1'b1);
        countIn <= 16'h0000;
        rdr(3'h3);
        wr(3'h3, 8'h58);
        repeat (3) @(posedge ref_clk);
        cmp1(chanIrq, 1'b0);
        cmp1(chanPinOe, 1'b1);
        wr(3'h3, 8'h68);
        wr(3'h5, 8'h00);
        repeat (3) @(posedge ref_clk);
        cmp1(chanIrq, 1'b0);
        cmp1(chanPinOe, 1'b1);
        wr(3'h5, 8'h05);
        countIn <= 16'h0003;
        repeat (3) @(posedge ref_clk);
        cmp1(chanPinOut, 1'b1);
        countIn <= 16'h0005;
        repeat (3) @(posedge ref_clk);
        cmp1(chanIrq, 1'b1);
        cmp1(chanPinOut, 1'b0);
        countIn <= 16'h0000;
        backgroundDebugMode <= 1'b1;
        wr(3'h1, 8'h12);
        cmp(moduloValue, 16'h12ff);
        backgroundDebugMode <= 1'b0;
        wr(3'h1, 8'h56);
        cmp(moduloValue, 16'h12ff);
        wr(3'h0, 8'h00);
        wr(3'h2, 8'h78);
        cmp(moduloValue, 16'h12ff);
        wr(3'h1, 8'h11);
        cmp(moduloValue, 16'h1178);
        wr(3'h1, 8'h9a);
        backgroundDebugMode <= 1'b1;
        wr(3'h2, 8'h22);
        backgroundDebugMode <= 1'b0;
        wr(3'h2, 8'h33);
        cmp(moduloValue, 16'h9a33);
        arst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        rdr(3'h3);
        cmp({8'h00, rd}, 16'h0000);
        wrap_up();
    end
endmodule : tb_top

`default_nettype wire
